// ---- src/cfs_status_flags.sv ----
// Purpose: live fault status and sticky charger event flags with clear-on-read
// Assumes: condition inputs are synchronous to CLK; host reads through RD_EN/RD_ADDR
// Notes:   RD_DATA and RD_VALID appear one cycle after the read request

`timescale 1ns/1ns
`default_nettype none

module cfs_status_flags
  import cfs_pkg::*;
(
  input  wire logic              CLK,
  input  wire logic              ARST_N,
  input  wire cfs_fault_in_t     FAULT_IN,
  input  wire cfs_cond_in_t      COND_IN,
  input  wire logic              RD_EN,
  input  wire logic [ADDR_W-1:0] RD_ADDR,
  output var  logic [DATA_W-1:0] RD_DATA,
  output var  logic              RD_VALID
);

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  function automatic logic reads_reg(input logic en, input logic [ADDR_W-1:0] addr,
                                     input logic [ADDR_W-1:0] ofs);
    reads_reg = en && (addr == ofs);
  endfunction

  logic              clr_a;
  logic              clr_b;
  logic              clr_c;
  logic [DATA_W-1:0] fault_r;
  logic [DATA_W-1:0] flags_a;
  logic [DATA_W-1:0] flags_b;
  logic [DATA_W-1:0] flags_c;
  logic [DATA_W-1:0] rd_data_r;
  logic [DATA_W-1:0] rd_data_nxt;
  logic              rd_valid_r;

  // reading a flag register clears it
  assign clr_a = reads_reg(RD_EN, RD_ADDR, EVENT_FLAGS_A_OFS);
  assign clr_b = reads_reg(RD_EN, RD_ADDR, EVENT_FLAGS_B_OFS);
  assign clr_c = reads_reg(RD_EN, RD_ADDR, EVENT_FLAGS_C_OFS);

  // ----------------------------------------------------------------
  // live fault status
  // ----------------------------------------------------------------
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      fault_r <= REG_RESET_VAL;
    end else begin
      fault_r                   <= REG_RESET_VAL;
      fault_r[FS_SYS_SHORT_BIT] <= FAULT_IN.system_short_status;
      fault_r[FS_SYS_OVP_BIT]   <= FAULT_IN.system_overvoltage_status;
      fault_r[FS_OTG_OVP_BIT]   <= FAULT_IN.otg_overvoltage_status;
      fault_r[FS_OTG_UVP_BIT]   <= FAULT_IN.otg_undervoltage_status;
      fault_r[FS_TSHUTDOWN_BIT] <= FAULT_IN.thermal_shutdown_status;
    end
  end

  // ----------------------------------------------------------------
  // flags A
  // ----------------------------------------------------------------
  // either regulation loop rising sets the flag
  cfs_flag_cell #(.W(2), .RISE_ONLY(1'b1)) u_fa_current (
    .clk     (CLK),
    .arst_n  (ARST_N),
    .sample  ({COND_IN.input_current_regulation, COND_IN.otg_current_regulation}),
    .qualify (1'b1),
    .clear   (clr_a),
    .flag    (flags_a[FA_CURRENT_REG_BIT])
  );

  cfs_flag_cell #(.W(2), .RISE_ONLY(1'b1)) u_fa_voltage (
    .clk     (CLK),
    .arst_n  (ARST_N),
    .sample  ({COND_IN.input_voltage_regulation, COND_IN.otg_voltage_regulation}),
    .qualify (1'b1),
    .clear   (clr_a),
    .flag    (flags_a[FA_VOLTAGE_REG_BIT])
  );

  cfs_flag_cell #(.W(1), .RISE_ONLY(1'b1)) u_fa_watchdog (
    .clk     (CLK),
    .arst_n  (ARST_N),
    .sample  (COND_IN.watchdog_expired),
    .qualify (1'b1),
    .clear   (clr_a),
    .flag    (flags_a[FA_WATCHDOG_BIT])
  );

  cfs_flag_cell #(.W(1), .RISE_ONLY(1'b1)) u_fa_weak (
    .clk     (CLK),
    .arst_n  (ARST_N),
    .sample  (COND_IN.weak_source_detected),
    .qualify (1'b1),
    .clear   (clr_a),
    .flag    (flags_a[FA_WEAK_SRC_BIT])
  );

  // both qualification and loss count
  cfs_flag_cell #(.W(1), .RISE_ONLY(1'b0)) u_fa_pgood (
    .clk     (CLK),
    .arst_n  (ARST_N),
    .sample  (COND_IN.power_good_status),
    .qualify (1'b1),
    .clear   (clr_a),
    .flag    (flags_a[FA_POWER_GOOD_BIT])
  );

  // one change detector per input presence
  cfs_flag_cell #(.W(1), .RISE_ONLY(1'b0)) u_fa_second (
    .clk     (CLK),
    .arst_n  (ARST_N),
    .sample  (COND_IN.second_ac_input_present),
    .qualify (1'b1),
    .clear   (clr_a),
    .flag    (flags_a[FA_SECOND_IN_BIT])
  );

  cfs_flag_cell #(.W(1), .RISE_ONLY(1'b0)) u_fa_first (
    .clk     (CLK),
    .arst_n  (ARST_N),
    .sample  (COND_IN.first_ac_input_present),
    .qualify (1'b1),
    .clear   (clr_a),
    .flag    (flags_a[FA_FIRST_IN_BIT])
  );

  cfs_flag_cell #(.W(1), .RISE_ONLY(1'b0)) u_fa_bus (
    .clk     (CLK),
    .arst_n  (ARST_N),
    .sample  (COND_IN.bus_input_present),
    .qualify (1'b1),
    .clear   (clr_a),
    .flag    (flags_a[FA_BUS_IN_BIT])
  );

  // ----------------------------------------------------------------
  // flags B
  // ----------------------------------------------------------------
  cfs_flag_cell #(.W(CHG_STATE_W), .RISE_ONLY(1'b0)) u_fb_charge (
    .clk     (CLK),
    .arst_n  (ARST_N),
    .sample  (COND_IN.charge_state),
    .qualify (1'b1),
    .clear   (clr_b),
    .flag    (flags_b[FB_CHARGE_BIT])
  );

  cfs_flag_cell #(.W(ICO_STATE_W), .RISE_ONLY(1'b0)) u_fb_optimizer (
    .clk     (CLK),
    .arst_n  (ARST_N),
    .sample  (COND_IN.input_current_optimizer_state),
    .qualify (1'b1),
    .clear   (clr_b),
    .flag    (flags_b[FB_OPTIMIZER_BIT])
  );

  cfs_flag_cell #(.W(BUS_TYPE_W), .RISE_ONLY(1'b0)) u_fb_bus_type (
    .clk     (CLK),
    .arst_n  (ARST_N),
    .sample  (COND_IN.bus_type),
    .qualify (1'b1),
    .clear   (clr_b),
    .flag    (flags_b[FB_BUS_TYPE_BIT])
  );

  cfs_flag_cell #(.W(1), .RISE_ONLY(1'b1)) u_fb_thermal (
    .clk     (CLK),
    .arst_n  (ARST_N),
    .sample  (COND_IN.die_thermal_regulation),
    .qualify (1'b1),
    .clear   (clr_b),
    .flag    (flags_b[FB_THERMAL_BIT])
  );

  cfs_flag_cell #(.W(1), .RISE_ONLY(1'b0)) u_fb_battery (
    .clk     (CLK),
    .arst_n  (ARST_N),
    .sample  (COND_IN.battery_present),
    .qualify (1'b1),
    .clear   (clr_b),
    .flag    (flags_b[FB_BATTERY_BIT])
  );

  // ----------------------------------------------------------------
  // flags C
  // ----------------------------------------------------------------
  // completion is the rise of the done level
  cfs_flag_cell #(.W(1), .RISE_ONLY(1'b1)) u_fc_usb (
    .clk     (CLK),
    .arst_n  (ARST_N),
    .sample  (COND_IN.usb_detect_done),
    .qualify (1'b1),
    .clear   (clr_c),
    .flag    (flags_c[FC_USB_DONE_BIT])
  );

  // continuous conversions never raise the flag
  cfs_flag_cell #(.W(1), .RISE_ONLY(1'b1)) u_fc_adc (
    .clk     (CLK),
    .arst_n  (ARST_N),
    .sample  (COND_IN.adc_conversion_done),
    .qualify (COND_IN.adc_one_shot_mode),
    .clear   (clr_c),
    .flag    (flags_c[FC_ADC_DONE_BIT])
  );

  cfs_flag_cell #(.W(1), .RISE_ONLY(1'b0)) u_fc_min_sys (
    .clk     (CLK),
    .arst_n  (ARST_N),
    .sample  (COND_IN.minimum_system_voltage_reg),
    .qualify (1'b1),
    .clear   (clr_c),
    .flag    (flags_c[FC_MIN_SYS_BIT])
  );

  cfs_flag_cell #(.W(1), .RISE_ONLY(1'b1)) u_fc_fast (
    .clk     (CLK),
    .arst_n  (ARST_N),
    .sample  (COND_IN.fast_charge_timer_expired),
    .qualify (1'b1),
    .clear   (clr_c),
    .flag    (flags_c[FC_FAST_TMR_BIT])
  );

  cfs_flag_cell #(.W(1), .RISE_ONLY(1'b1)) u_fc_trickle (
    .clk     (CLK),
    .arst_n  (ARST_N),
    .sample  (COND_IN.trickle_timer_expired),
    .qualify (1'b1),
    .clear   (clr_c),
    .flag    (flags_c[FC_TRICKLE_TMR_BIT])
  );

  cfs_flag_cell #(.W(1), .RISE_ONLY(1'b1)) u_fc_pre (
    .clk     (CLK),
    .arst_n  (ARST_N),
    .sample  (COND_IN.precharge_timer_expired),
    .qualify (1'b1),
    .clear   (clr_c),
    .flag    (flags_c[FC_PRE_TMR_BIT])
  );

  // unused positions tied low
  assign flags_b[5]                 = 1'b0;
  assign flags_b[3]                 = 1'b0;
  assign flags_b[0]                 = 1'b0;
  assign flags_c[7]                 = 1'b0;
  assign flags_c[0]                 = 1'b0;

  // ----------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------
  always_comb begin
    if (RD_ADDR == FAULT_STATUS_SECOND_OFS) begin
      rd_data_nxt = fault_r & FS_USED_MASK;
    end else if (RD_ADDR == EVENT_FLAGS_A_OFS) begin
      rd_data_nxt = flags_a;
    end else if (RD_ADDR == EVENT_FLAGS_B_OFS) begin
      rd_data_nxt = flags_b & FB_USED_MASK;
    end else if (RD_ADDR == EVENT_FLAGS_C_OFS) begin
      rd_data_nxt = flags_c & FC_USED_MASK;
    end else begin
      rd_data_nxt = UNMAPPED_VAL;
    end
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rd_data_r  <= REG_RESET_VAL;
      rd_valid_r <= 1'b0;
    end else begin
      rd_valid_r <= RD_EN;
      if (RD_EN) begin
        rd_data_r <= rd_data_nxt;
      end
    end
  end

  assign RD_DATA  = rd_data_r;
  assign RD_VALID = rd_valid_r;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!ARST_N);

  sequence read_of_a;
    RD_EN && (RD_ADDR == EVENT_FLAGS_A_OFS);
  endsequence

  sequence watchdog_rise;
    $rose(COND_IN.watchdog_expired);
  endsequence

  chk_short_tracks: assert property (
    FAULT_IN.system_short_status |=> fault_r[FS_SYS_SHORT_BIT])
    else $error("short status bit did not follow input");

  chk_tshut_tracks: assert property (
    !FAULT_IN.thermal_shutdown_status |=> !fault_r[FS_TSHUTDOWN_BIT])
    else $error("thermal shutdown bit stayed high");

  chk_reserved_zero: assert property (
    ((fault_r & ~FS_USED_MASK) == '0) && (flags_c[7] == 1'b0) && !flags_b[5])
    else $error("reserved bit is not zero");

  chk_watchdog_set: assert property (
    watchdog_rise |=> flags_a[FA_WATCHDOG_BIT])
    else $error("watchdog flag missed a rising edge");

  chk_set_beats_clear: assert property (
    (watchdog_rise and read_of_a) |=> flags_a[FA_WATCHDOG_BIT])
    else $error("event lost against clear-on-read");

  chk_flag_holds: assert property (
    (flags_a[FA_POWER_GOOD_BIT] && !clr_a) |=> flags_a[FA_POWER_GOOD_BIT])
    else $error("flag dropped without a read");

  chk_pgood_change: assert property (
    $changed(COND_IN.power_good_status) |=> flags_a[FA_POWER_GOOD_BIT])
    else $error("power good change not flagged");

  chk_adc_one_shot: assert property (
    ($rose(COND_IN.adc_conversion_done) && !COND_IN.adc_one_shot_mode
     && !flags_c[FC_ADC_DONE_BIT]) |=> !flags_c[FC_ADC_DONE_BIT])
    else $error("adc flag set outside one-shot mode");

  chk_timer_set: assert property (
    $rose(COND_IN.fast_charge_timer_expired) |=> flags_c[FC_FAST_TMR_BIT])
    else $error("fast charge timer flag missed");

  chk_read_returns: assert property (
    (read_of_a ##1 RD_VALID) |-> (RD_DATA == $past(flags_a)))
    else $error("read data does not match flags");

endmodule

`default_nettype wire

// ---- common/cfs_pkg.sv ----
// Purpose: shared constants and carriers of the charger fault status and event flag bank
// Assumes: one clock domain, registers read through a simple read port
// Notes:   offsets are byte addresses of the device register space

package cfs_pkg;

  // ----------------------------------------------------------------
  // register space
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;

  localparam logic [ADDR_W-1:0] FAULT_STATUS_SECOND_OFS = 8'h21;
  localparam logic [ADDR_W-1:0] EVENT_FLAGS_A_OFS       = 8'h22;
  localparam logic [ADDR_W-1:0] EVENT_FLAGS_B_OFS       = 8'h23;
  localparam logic [ADDR_W-1:0] EVENT_FLAGS_C_OFS       = 8'h24;

  localparam logic [DATA_W-1:0] REG_RESET_VAL  = 8'h00;
  localparam logic [DATA_W-1:0] UNMAPPED_VAL   = 8'h00;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int unsigned FS_SYS_SHORT_BIT   = 7;
  localparam int unsigned FS_SYS_OVP_BIT     = 6;
  localparam int unsigned FS_OTG_OVP_BIT     = 5;
  localparam int unsigned FS_OTG_UVP_BIT     = 4;
  localparam int unsigned FS_TSHUTDOWN_BIT   = 2;
  localparam logic [DATA_W-1:0] FS_USED_MASK = 8'hF4;

  localparam int unsigned FA_CURRENT_REG_BIT = 7;
  localparam int unsigned FA_VOLTAGE_REG_BIT = 6;
  localparam int unsigned FA_WATCHDOG_BIT    = 5;
  localparam int unsigned FA_WEAK_SRC_BIT    = 4;
  localparam int unsigned FA_POWER_GOOD_BIT  = 3;
  localparam int unsigned FA_SECOND_IN_BIT   = 2;
  localparam int unsigned FA_FIRST_IN_BIT    = 1;
  localparam int unsigned FA_BUS_IN_BIT      = 0;

  localparam int unsigned FB_CHARGE_BIT      = 7;
  localparam int unsigned FB_OPTIMIZER_BIT   = 6;
  localparam int unsigned FB_BUS_TYPE_BIT    = 4;
  localparam int unsigned FB_THERMAL_BIT     = 2;
  localparam int unsigned FB_BATTERY_BIT     = 1;
  localparam logic [DATA_W-1:0] FB_USED_MASK = 8'hD6;

  localparam int unsigned FC_USB_DONE_BIT    = 6;
  localparam int unsigned FC_ADC_DONE_BIT    = 5;
  localparam int unsigned FC_MIN_SYS_BIT     = 4;
  localparam int unsigned FC_FAST_TMR_BIT    = 3;
  localparam int unsigned FC_TRICKLE_TMR_BIT = 2;
  localparam int unsigned FC_PRE_TMR_BIT     = 1;
  localparam logic [DATA_W-1:0] FC_USED_MASK = 8'h7E;

  // ----------------------------------------------------------------
  // widths of multi-bit status codes
  // ----------------------------------------------------------------
  localparam int unsigned CHG_STATE_W = 3;
  localparam int unsigned ICO_STATE_W = 2;
  localparam int unsigned BUS_TYPE_W  = 4;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic system_short_status;
    logic system_overvoltage_status;
    logic otg_overvoltage_status;
    logic otg_undervoltage_status;
    logic thermal_shutdown_status;
  } cfs_fault_in_t;

  typedef struct packed {
    logic                   input_current_regulation;
    logic                   otg_current_regulation;
    logic                   input_voltage_regulation;
    logic                   otg_voltage_regulation;
    logic                   watchdog_expired;
    logic                   weak_source_detected;
    logic                   power_good_status;
    logic                   second_ac_input_present;
    logic                   first_ac_input_present;
    logic                   bus_input_present;
    logic [CHG_STATE_W-1:0] charge_state;
    logic [ICO_STATE_W-1:0] input_current_optimizer_state;
    logic [BUS_TYPE_W-1:0]  bus_type;
    logic                   die_thermal_regulation;
    logic                   battery_present;
    logic                   usb_detect_done;
    logic                   adc_conversion_done;
    logic                   adc_one_shot_mode;
    logic                   minimum_system_voltage_reg;
    logic                   fast_charge_timer_expired;
    logic                   trickle_timer_expired;
    logic                   precharge_timer_expired;
  } cfs_cond_in_t;

endpackage

// ---- src/cfs_flag_cell.sv ----
// Purpose: one sticky event flag fed by an edge or change detector
// Assumes: sample is synchronous to clk
// Notes:   a set in the same cycle as a clear wins

`timescale 1ns/1ns
`default_nettype none

module cfs_flag_cell #(
  parameter int unsigned W         = 1,
  parameter bit          RISE_ONLY = 1'b1
) (
  input  wire logic         clk,
  input  wire logic         arst_n,
  input  wire logic [W-1:0] sample,
  input  wire logic         qualify,
  input  wire logic         clear,
  output var  logic         flag
);

  logic [W-1:0] prev_r;
  logic         event_hit;
  logic         flag_r;
  logic         flag_nxt;

  // ----------------------------------------------------------------
  // detector
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      prev_r <= '0;
    end else begin
      prev_r <= sample;
    end
  end

  always_comb begin
    if (RISE_ONLY) begin
      event_hit = qualify & (|(sample & ~prev_r));
    end else begin
      event_hit = qualify & (|(sample ^ prev_r));
    end
  end

  // ----------------------------------------------------------------
  // sticky flag
  // ----------------------------------------------------------------
  always_comb begin
    flag_nxt = event_hit | (flag_r & ~clear);
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      flag_r <= 1'b0;
    end else begin
      flag_r <= flag_nxt;
    end
  end

  assign flag = flag_r;

endmodule

`default_nettype wire

// ---- src/cfs_status_flags_fix_note.sv ----
`timescale 1ns/1ns

// ---- test/cfs_host_model.sv ----
// Purpose: host side of the register read port of the status and flag bank
// Assumes: reads start after reset is released
// Notes:   address is scrambled once released so a stale value is never reused

`timescale 1ns/1ns
`default_nettype none

module cfs_host_model
  import cfs_pkg::*;
(
  input  wire logic              CLK,
  output var  logic              RD_EN,
  output var  logic [ADDR_W-1:0] RD_ADDR,
  input  wire logic [DATA_W-1:0] RD_DATA,
  input  wire logic              RD_VALID
);
  initial begin
    RD_EN   = 1'b0;
    RD_ADDR = 8'h00;
  end

  // ----------------------------------------------------------------
  // single byte read, answer sampled just after the taken edge
  // ----------------------------------------------------------------
  task automatic read(input logic [ADDR_W-1:0] addr, output logic [DATA_W-1:0] data,
                      output bit pulse_ok);
    @(posedge CLK);
    RD_EN   <= 1'b1;
    RD_ADDR <= addr;
    @(posedge CLK);
    RD_EN   <= 1'b0;
    RD_ADDR <= ~addr;
    #1;
    data     = RD_DATA;
    pulse_ok = (RD_VALID === 1'b1);
    @(posedge CLK);
    #1;
    pulse_ok = pulse_ok && (RD_VALID === 1'b0);
  endtask
endmodule

`default_nettype wire

// ---- test/charger_fault_status_and_event_flags_test.sv ----
// Purpose: self-checking bench of the fault status and event flag bank
// Assumes: host model issues all reads
// Notes:   each row applies condition levels, reads one register, then clears all flags

`timescale 1ns/1ns
`default_nettype none

module charger_fault_status_and_event_flags_test
  import cfs_pkg::*;
  ;
  typedef struct packed {
    cfs_fault_in_t     fault;
    cfs_cond_in_t      cond;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] exp;
  } cfs_row_t;

  logic              clk = 1'b0;
  logic              arst_n = 1'b0;
  cfs_fault_in_t     fault_in = '0;
  cfs_cond_in_t      cond_in = '0;
  logic              rd_en;
  logic [ADDR_W-1:0] rd_addr;
  logic [DATA_W-1:0] rd_data;
  logic              rd_valid;
  int                err_total = 0;
  int                comparisons = 0;

  cfs_row_t rows [31] = '{
    '{5'h00, 28'h8000000, 8'h22, 8'h80},
    '{5'h00, 28'h4000000, 8'h22, 8'h80},
    '{5'h00, 28'h2000000, 8'h22, 8'h40},
    '{5'h00, 28'h1000000, 8'h22, 8'h40},
    '{5'h00, 28'h0000000, 8'h22, 8'h00},
    '{5'h00, 28'h0800000, 8'h22, 8'h20},
    '{5'h00, 28'h0400000, 8'h22, 8'h10},
    '{5'h00, 28'h0200000, 8'h22, 8'h08},
    '{5'h00, 28'h0000000, 8'h22, 8'h08},
    '{5'h00, 28'h01C0000, 8'h22, 8'h07},
    '{5'h00, 28'h0000000, 8'h22, 8'h07},
    '{5'h00, 28'h0028000, 8'h23, 8'h80},
    '{5'h00, 28'h002C000, 8'h23, 8'h40},
    '{5'h00, 28'h002D200, 8'h23, 8'h10},
    '{5'h00, 28'h002D300, 8'h23, 8'h04},
    '{5'h00, 28'h002D380, 8'h23, 8'h02},
    '{5'h00, 28'h0000000, 8'h23, 8'hD2},
    '{5'h00, 28'h0000040, 8'h24, 8'h40},
    '{5'h00, 28'h0000020, 8'h24, 8'h00},
    '{5'h00, 28'h0000000, 8'h24, 8'h00},
    '{5'h00, 28'h0000030, 8'h24, 8'h20},
    '{5'h00, 28'h0000018, 8'h24, 8'h10},
    '{5'h00, 28'h0000010, 8'h24, 8'h10},
    '{5'h00, 28'h0000017, 8'h24, 8'h0E},
    '{5'h00, 28'h0000000, 8'h24, 8'h00},
    '{5'h10, 28'h0000000, 8'h21, 8'h80},
    '{5'h08, 28'h0000000, 8'h21, 8'h40},
    '{5'h04, 28'h0000000, 8'h21, 8'h20},
    '{5'h02, 28'h0000000, 8'h21, 8'h10},
    '{5'h01, 28'h0000000, 8'h21, 8'h04},
    '{5'h1F, 28'h0000000, 8'h21, 8'hF4}
  };

  always #50 clk = ~clk;

  cfs_status_flags dut_u (
    .CLK      (clk),
    .ARST_N   (arst_n),
    .FAULT_IN (fault_in),
    .COND_IN  (cond_in),
    .RD_EN    (rd_en),
    .RD_ADDR  (rd_addr),
    .RD_DATA  (rd_data),
    .RD_VALID (rd_valid)
  );

  cfs_host_model host_u (
    .CLK      (clk),
    .RD_EN    (rd_en),
    .RD_ADDR  (rd_addr),
    .RD_DATA  (rd_data),
    .RD_VALID (rd_valid)
  );

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [DATA_W-1:0] exp,
                       input logic [DATA_W-1:0] got);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp, input string what);
    logic [DATA_W-1:0] d;
    bit                ok;
    host_u.read(a, d, ok);
    check({what, " valid pulse"}, 8'h01, {7'h00, ok});
    check(what, exp, d);
  endtask

  task automatic flush();
    logic [DATA_W-1:0] d;
    bit                ok;
    for (int a = 8'h22; a <= 8'h24; a++) begin
      host_u.read(a[ADDR_W-1:0], d, ok);
    end
  endtask

  task automatic set_cond(input logic [27:0] c);
    @(posedge clk);
    cond_in <= c;
    repeat (2) @(posedge clk);
  endtask

  task automatic all_zero();
    for (int a = 8'h21; a <= 8'h24; a++) begin
      rd(a[ADDR_W-1:0], REG_RESET_VAL, $sformatf("reset value %h", a));
    end
  endtask

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    #500000;
    err_total++;
    $display("watchdog expired");
    test_done();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    all_zero();
    foreach (rows[i]) begin
      @(posedge clk);
      fault_in <= rows[i].fault;
      cond_in  <= rows[i].cond;
      repeat (2) @(posedge clk);
      rd(rows[i].addr, rows[i].exp, $sformatf("row %0d", i));
      flush();
    end
    $display("test rows done");
    set_cond(28'h0800000);
    rd(8'h22, 8'h20, "latched flag");
    rd(8'h22, 8'h00, "flag after read");
    set_cond(28'h0000000);
    $display("test clear on read done");
    fork
      rd(8'h22, 8'h00, "read during event");
      begin
        @(posedge clk);
        cond_in <= 28'h0800000;
      end
    join
    rd(8'h22, 8'h20, "event beside read");
    $display("test set beside clear done");
    set_cond(28'h0200000);
    rd(8'h25, 8'h00, "unmapped read");
    rd(8'h22, 8'h08, "flag after unmapped read");
    set_cond(28'h0000000);
    $display("test unmapped done");
    @(posedge clk);
    fault_in <= 5'h1F;
    set_cond(28'h01C0000);
    @(posedge clk);
    fault_in <= 5'h00;
    cond_in  <= 28'h0000000;
    arst_n   <= 1'b0;
    repeat (16) @(posedge clk);
    check("valid in reset", 8'h00, {7'h00, rd_valid});
    arst_n <= 1'b1;
    all_zero();
    $display("test reset done");
    test_done();
  end
endmodule

`default_nettype wire
